// ---- common/adcsc_pkg.sv ----
// Purpose: Shared constants and types for the converter start control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Offsets are byte addresses
`default_nettype none
package adcsc_pkg;
  localparam int ADDR_W = 8;
  localparam int CH_W   = 5;
  localparam int DEP_W  = 3;
  localparam int RES_W  = 12;
  localparam int FIFO_D = 8;
  localparam int CNT_W  = 4;

  localparam logic [ADDR_W-1:0] OFS_SC1  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FIFO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RES  = 8'h0c;

  // converter_status_control_first fields
  localparam int SC1_DONE_BIT = 7;
  localparam int SC1_IRQ_BIT  = 6;
  localparam int SC1_CONT_BIT = 5;
  // Control word fields
  localparam int CTRL_HW_BIT   = 0;
  localparam int CTRL_CMP_BIT  = 1;
  localparam int CTRL_BUSY_BIT = 2;
  // FIFO word fields
  localparam int FIFO_MULTI_BIT = 4;

  localparam logic [CH_W-1:0]  RST_CHAN   = 5'h1f;
  localparam logic [CH_W-1:0]  CH_DISABLE = 5'h1f;
  localparam logic [DEP_W-1:0] RST_DEPTH  = 3'h0;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ARM   = 4'b0010,
    ST_START = 4'b0100,
    ST_CONV  = 4'b1000
  } adcsc_st_t;
endpackage
`default_nettype wire

// ---- rtl/adcsc_chan_fifo.sv ----
// Purpose: Channel queue for batch conversion sets
// Assumes: Read index stays below the fill count
// Notes:   Pushes beyond depth D are dropped
`timescale 1ns/10ps
`default_nettype none
module adcsc_chan_fifo #(
  parameter int W  = 5,
  parameter int D  = 8,
  parameter int CW = 4
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_b,
  input  wire logic          i_clr,
  input  wire logic          i_push,
  input  wire logic [W-1:0]  i_data,
  input  wire logic [2:0]    i_idx,
  output logic      [W-1:0]  o_data,
  output logic      [CW-1:0] o_count
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [CW-1:0]       cnt;
  } adcsc_fifo_t;

  adcsc_fifo_t r, n;

  always_comb begin
    n = r;
    if (i_clr) begin
      n.cnt = '0;
    end else if (i_push && (r.cnt < CW'(D))) begin
      n.mem[r.cnt[2:0]] = i_data;
      n.cnt = r.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_data  = r.mem[i_idx];
  assign o_count = r.cnt;
endmodule
`default_nettype wire

// ---- rtl/adcsc_result_hold.sv ----
// Purpose: Holds the last accepted conversion result
// Assumes: Load is a one-cycle pulse
// Notes:   Cleared only by reset
`timescale 1ns/10ps
`default_nettype none
module adcsc_result_hold #(
  parameter int W = 12
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_data,
  output logic      [W-1:0] o_data
);
  typedef struct packed {
    logic [W-1:0] val;
  } adcsc_res_t;

  adcsc_res_t r, n;

  always_comb begin
    n = r;
    if (i_load) begin
      n.val = i_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_data = r.val;
endmodule
`default_nettype wire

// ---- rtl/adcsc_top.sv ----
// Purpose: Start and completion control of a successive-approximation converter
// Assumes: Hardware trigger is a one-cycle pulse on i_mclk; converter core answers with i_conv_done
// Notes:   APB slave with zero wait states; unmapped addresses answer with pslverr
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Done flag set while done interrupt enable is 1 raises the interrupt.
// - Continuous enable picks single conversions at 0, continuous at 1.
// - Single mode, software trigger: one conversion per control register write.
// - Single mode, hardware trigger: one conversion per trigger pulse.
// - Single mode with FIFO depth above 0: a trigger runs a whole set; with multi clear each hardware pulse runs one channel.
// - Continuous, software trigger: back-to-back conversions after a control write.
// - Continuous, hardware trigger: back-to-back conversions after a trigger pulse.
// - Continuous with FIFO depth above 0: the set repeats in a loop.
// - Channel select is 5 bits; codes 0 to 15 pick external inputs.
// - Done flag is read-only; set per conversion, compare hit, or set end.
// - Control register write or result read clears the done flag.
// - Control register write aborts a running conversion and starts anew, or rearms for a trigger pulse with hardware trigger.
// - Channel code all ones disables, stops conversion and empties the FIFO.
module adcsc_top (
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [adcsc_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]                i_pwdata,
  output logic      [31:0]                o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  input  wire logic                       i_hw_trigger,
  input  wire logic                       i_conv_done,
  input  wire logic                       i_cmp_true,
  input  wire logic [adcsc_pkg::RES_W-1:0]  i_conv_data,
  output logic                            o_conv_start,
  output logic                            o_conv_abort,
  output logic      [adcsc_pkg::CH_W-1:0]   o_conv_channel,
  output logic                            o_done_irq
);
  typedef struct packed {
    logic                          irq_en;
    logic                          cont;
    logic                          done;
    logic                          trig_hw;
    logic                          cmp_en;
    logic                          multi;
    logic [adcsc_pkg::CH_W-1:0]    chan;
    logic [adcsc_pkg::DEP_W-1:0]   depth;
    logic [2:0]                    idx;
    logic [adcsc_pkg::CH_W-1:0]    conv_ch;
    logic                          start;
    logic                          abort;
    adcsc_pkg::adcsc_st_t          st;
  } adcsc_state_t;

  adcsc_state_t r, n;

  logic                           acc;
  logic                           wr_sc1;
  logic                           wr_ctrl;
  logic                           wr_fifo;
  logic                           rd_res;
  logic                           mapped;
  logic                           fifo_mode;
  logic                           fifo_clr;
  logic                           fifo_push;
  logic                           res_load;
  logic                           ok;
  logic                           last;
  logic [adcsc_pkg::CH_W-1:0]     fifo_ch;
  logic [adcsc_pkg::CNT_W-1:0]    fifo_cnt;
  logic [adcsc_pkg::RES_W-1:0]    res_val;
  logic [adcsc_pkg::CH_W-1:0]     wr_ch;

  assign acc       = i_psel && i_penable;
  assign mapped    = (i_paddr == adcsc_pkg::OFS_SC1) || (i_paddr == adcsc_pkg::OFS_CTRL)
                  || (i_paddr == adcsc_pkg::OFS_FIFO) || (i_paddr == adcsc_pkg::OFS_RES);
  assign wr_sc1    = acc && i_pwrite && (i_paddr == adcsc_pkg::OFS_SC1);
  assign wr_ctrl   = acc && i_pwrite && (i_paddr == adcsc_pkg::OFS_CTRL);
  assign wr_fifo   = acc && i_pwrite && (i_paddr == adcsc_pkg::OFS_FIFO);
  assign rd_res    = acc && !i_pwrite && (i_paddr == adcsc_pkg::OFS_RES);
  assign wr_ch     = i_pwdata[adcsc_pkg::CH_W-1:0];
  assign fifo_mode = (r.depth != adcsc_pkg::RST_DEPTH);
  assign ok        = !r.cmp_en || i_cmp_true;
  assign last      = !fifo_mode || (r.idx == r.depth);

  adcsc_chan_fifo #(
    .W  (adcsc_pkg::CH_W),
    .D  (adcsc_pkg::FIFO_D),
    .CW (adcsc_pkg::CNT_W)
  ) u_fifo (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_clr   (fifo_clr),
    .i_push  (fifo_push),
    .i_data  (wr_ch),
    .i_idx   (r.idx),
    .o_data  (fifo_ch),
    .o_count (fifo_cnt)
  );

  adcsc_result_hold #(
    .W (adcsc_pkg::RES_W)
  ) u_res (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_load  (res_load),
    .i_data  (i_conv_data),
    .o_data  (res_val)
  );

  always_comb begin
    n         = r;
    n.start   = 1'b0;
    n.abort   = 1'b0;
    fifo_clr  = 1'b0;
    fifo_push = 1'b0;
    res_load  = 1'b0;
    // Clears first so that a completion in the same cycle wins
    if (wr_sc1 || rd_res) begin
      n.done = 1'b0;
    end
    case (r.st)
      adcsc_pkg::ST_IDLE: begin
        n.idx = '0;
      end
      adcsc_pkg::ST_ARM: begin
        if (i_hw_trigger) begin
          n.st = adcsc_pkg::ST_START;
        end
      end
      adcsc_pkg::ST_START: begin
        n.start   = 1'b1;
        n.conv_ch = fifo_mode ? fifo_ch : r.chan;
        n.st      = adcsc_pkg::ST_CONV;
      end
      adcsc_pkg::ST_CONV: begin
        if (i_conv_done) begin
          res_load = ok;
          if (!last) begin
            n.idx = r.idx + 3'd1;
            // Without multi-trigger each pulse walks one channel of the set
            n.st  = (r.trig_hw && !r.multi && !r.cont) ? adcsc_pkg::ST_ARM
                                                       : adcsc_pkg::ST_START;
          end else begin
            n.idx = '0;
            if (ok) begin
              n.done = 1'b1;
            end
            if (r.cont) begin
              n.st = adcsc_pkg::ST_START;
            end else if (r.trig_hw) begin
              n.st = adcsc_pkg::ST_ARM;
            end else begin
              n.st = adcsc_pkg::ST_IDLE;
            end
          end
        end
      end
      default: begin
        n.st = adcsc_pkg::ST_IDLE;
      end
    endcase
    if (wr_sc1) begin
      n.irq_en = i_pwdata[adcsc_pkg::SC1_IRQ_BIT];
      n.cont   = i_pwdata[adcsc_pkg::SC1_CONT_BIT];
      n.chan   = wr_ch;
      n.idx    = '0;
      n.abort  = (r.st == adcsc_pkg::ST_CONV);
      if (wr_ch == adcsc_pkg::CH_DISABLE) begin
        n.st     = adcsc_pkg::ST_IDLE;
        fifo_clr = 1'b1;
      end else if (fifo_mode && (fifo_cnt < {1'b0, r.depth})) begin
        fifo_push = 1'b1;
        n.st      = adcsc_pkg::ST_IDLE;
      end else begin
        fifo_push = fifo_mode;
        n.st      = r.trig_hw ? adcsc_pkg::ST_ARM : adcsc_pkg::ST_START;
      end
    end
    if (wr_ctrl) begin
      n.trig_hw = i_pwdata[adcsc_pkg::CTRL_HW_BIT];
      n.cmp_en  = i_pwdata[adcsc_pkg::CTRL_CMP_BIT];
    end
    if (wr_fifo) begin
      n.depth  = i_pwdata[adcsc_pkg::DEP_W-1:0];
      n.multi  = i_pwdata[adcsc_pkg::FIFO_MULTI_BIT];
      fifo_clr = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      r       <= '0;
      r.chan  <= adcsc_pkg::RST_CHAN;
      r.depth <= adcsc_pkg::RST_DEPTH;
      r.st    <= adcsc_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    o_prdata = 32'h0;
    case (i_paddr)
      adcsc_pkg::OFS_SC1: begin
        o_prdata[adcsc_pkg::SC1_DONE_BIT] = r.done;
        o_prdata[adcsc_pkg::SC1_IRQ_BIT]  = r.irq_en;
        o_prdata[adcsc_pkg::SC1_CONT_BIT] = r.cont;
        o_prdata[adcsc_pkg::CH_W-1:0]     = r.chan;
      end
      adcsc_pkg::OFS_CTRL: begin
        o_prdata[adcsc_pkg::CTRL_HW_BIT]   = r.trig_hw;
        o_prdata[adcsc_pkg::CTRL_CMP_BIT]  = r.cmp_en;
        o_prdata[adcsc_pkg::CTRL_BUSY_BIT] = (r.st != adcsc_pkg::ST_IDLE);
      end
      adcsc_pkg::OFS_FIFO: begin
        o_prdata[adcsc_pkg::DEP_W-1:0]      = r.depth;
        o_prdata[adcsc_pkg::FIFO_MULTI_BIT] = r.multi;
      end
      adcsc_pkg::OFS_RES: begin
        o_prdata[adcsc_pkg::RES_W-1:0] = res_val;
      end
      default: begin
        o_prdata = 32'h0;
      end
    endcase
  end

  assign o_pready       = 1'b1;
  assign o_pslverr      = acc && !mapped;
  assign o_conv_start   = r.start;
  assign o_conv_abort   = r.abort;
  assign o_conv_channel = r.conv_ch;
  assign o_done_irq     = r.done && r.irq_en;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_irq_on_done: assert property ($rose(r.done) && r.irq_en |-> o_done_irq)
    else $error("done flag rose with enable but no interrupt");
  a_irq_masked: assert property (!r.irq_en |-> !o_done_irq)
    else $error("interrupt raised while disabled");
  a_sw_single_stop: assert property (r.st == adcsc_pkg::ST_CONV && i_conv_done && last && !r.cont
    && !r.trig_hw && !wr_sc1 |=> r.st == adcsc_pkg::ST_IDLE ##1 !o_conv_start)
    else $error("single software conversion did not stop");
  a_hw_rearm: assert property (r.st == adcsc_pkg::ST_CONV && i_conv_done && last && !r.cont
    && r.trig_hw && !wr_sc1 |=> r.st == adcsc_pkg::ST_ARM)
    else $error("hardware single mode did not rearm");
  a_arm_waits: assert property (r.st == adcsc_pkg::ST_ARM && !i_hw_trigger && !wr_sc1
    |=> r.st == adcsc_pkg::ST_ARM)
    else $error("conversion began without a trigger");
  a_trig_starts: assert property (r.st == adcsc_pkg::ST_ARM && i_hw_trigger && !wr_sc1
    |=> ##1 o_conv_start)
    else $error("trigger did not start a conversion");
  a_cont_loop: assert property (r.st == adcsc_pkg::ST_CONV && i_conv_done && r.cont && !wr_sc1
    |=> ##1 o_conv_start)
    else $error("continuous mode did not restart");
  a_write_starts: assert property (wr_sc1 && wr_ch != adcsc_pkg::CH_DISABLE && !fifo_mode
    && !r.trig_hw |=> ##1 o_conv_start && o_conv_channel == $past(wr_ch, 2))
    else $error("control write did not start on the written channel");
  a_write_aborts: assert property (wr_sc1 && r.st == adcsc_pkg::ST_CONV |=> o_conv_abort)
    else $error("running conversion not aborted");
  a_disable_stops: assert property (wr_sc1 && wr_ch == adcsc_pkg::CH_DISABLE
    |=> r.st == adcsc_pkg::ST_IDLE && fifo_cnt == '0)
    else $error("disable code did not stop and flush");
  a_done_clears: assert property ((wr_sc1 || rd_res) && !(r.st == adcsc_pkg::ST_CONV && i_conv_done)
    |=> !r.done)
    else $error("done flag not cleared");
  a_set_midway: assert property (r.st == adcsc_pkg::ST_CONV && i_conv_done && !last && !r.done
    && !wr_sc1 |=> !r.done)
    else $error("done flag set before the set finished");

  c_cont_loop: cover property (r.cont && o_conv_start ##[1:40] o_conv_start);
  c_set_done: cover property (fifo_mode && $rose(r.done));
  c_hw_trig: cover property (r.st == adcsc_pkg::ST_ARM && i_hw_trigger);
  c_irq: cover property ($rose(o_done_irq));
endmodule
`default_nettype wire

// ---- tb/test_adc_conversion_start_control.sv ----
// Purpose: Self-checking bench for the converter start control block
// Assumes: Zero-wait APB slave; converter core answers are driven by the bench
// Notes:   Compare input is raised only by the compare scenario
`timescale 1ns/10ps
`default_nettype none
module test_adc_conversion_start_control;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, slverr;
  logic        hw_trig = 1'b0, conv_done = 1'b0, cmp = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic        conv_start, conv_abort, done_irq, ab;
  logic [4:0]  conv_chan;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n;

  always #12.5 mclk = ~mclk;

  adcsc_top dut_u (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_hw_trigger(hw_trig), .i_conv_done(conv_done), .i_cmp_true(cmp), .i_conv_data(conv_data),
    .o_conv_start(conv_start), .o_conv_abort(conv_abort), .o_conv_channel(conv_chan), .o_done_irq(done_irq)
  );

  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the completing edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rdata = prdata;
    slverr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k == 20) begin
      chk(1'b0, 1'b1);
      complete_run;
    end
  endtask

  // Cycles until a start pulse, noting any abort pulse on the way
  task wait_start;
    ab = 1'b0;
    // Abort pulse stands in the cycle right after the completing edge
    #1;
    if (conv_abort === 1'b1) ab = 1'b1;
    for (n = 1; n <= 30; n++) begin
      @(posedge mclk);
      #1;
      if (conv_abort === 1'b1) ab = 1'b1;
      if (conv_start === 1'b1) break;
    end
    if (n > 30) begin
      chk(1'b0, 1'b1);
      complete_run;
    end
  endtask

  // Checks that no start pulse shows for c cycles
  task no_start(input int c);
    int s;
    s = 0;
    repeat (c) begin
      @(posedge mclk);
      #1;
      if (conv_start === 1'b1) s++;
    end
    chk(s, 0);
  endtask

  task finish(input logic [11:0] v);
    @(posedge mclk);
    conv_done <= 1'b1; conv_data <= v;
    @(posedge mclk);
    conv_done <= 1'b0;
  endtask

  task t_reset;
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata, 32'h0000001f);
    chk(done_irq, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk(slverr, 1'b1);
    $display("test reset done");
  endtask

  task t_single(input logic irq);
    apb(1'b1, 8'h00, {25'h0, irq, 6'h03});
    wait_start;
    chk(n, 1);
    chk(conv_chan, 5'h03);
    finish(12'h5a5);
    no_start(8);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata, {24'h0, 1'b1, irq, 6'h03});
    chk(done_irq, irq);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdata, 32'h000005a5);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata[7], 1'b0);
    chk(done_irq, 1'b0);
    $display("test single done");
  endtask

  task t_chan_abort;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 8'h00, c);
      wait_start;
      chk(conv_chan, c[4:0]);
      if (c > 0) chk(ab, 1'b1);
    end
    apb(1'b1, 8'h00, 32'h1f);
    #1;
    chk(conv_abort, 1'b1);
    no_start(10);
    $display("test channels done");
  endtask

  task t_hw;
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h00, 32'h05);
    no_start(5);
    @(posedge mclk);
    hw_trig <= 1'b1;
    @(posedge mclk);
    hw_trig <= 1'b0;
    wait_start;
    chk(n, 1);
    chk(conv_chan, 5'h05);
    finish(12'h123);
    apb(1'b1, 8'h00, 32'h1f);
    apb(1'b1, 8'h04, 32'h0);
    $display("test hardware done");
  endtask

  task t_cont;
    apb(1'b1, 8'h00, 32'h27);
    for (int i = 0; i < 3; i++) begin
      wait_start;
      chk(conv_chan, 5'h07);
      finish(12'h0f0);
    end
    wait_start;
    chk(n, 1);
    apb(1'b1, 8'h00, 32'h1f);
    $display("test continuous done");
  endtask

  task t_fifo;
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h00, 32'h02);
    no_start(4);
    apb(1'b1, 8'h00, 32'h04);
    wait_start;
    chk(conv_chan, 5'h02);
    finish(12'h011);
    wait_start;
    chk(conv_chan, 5'h04);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata[7], 1'b0);
    finish(12'h022);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata[7], 1'b1);
    apb(1'b1, 8'h00, 32'h1f);
    apb(1'b1, 8'h00, 32'h22);
    apb(1'b1, 8'h00, 32'h24);
    for (int i = 0; i < 3; i++) begin
      wait_start;
      chk(conv_chan, i[0] ? 5'h04 : 5'h02);
      finish(12'h033);
    end
    apb(1'b1, 8'h00, 32'h1f);
    apb(1'b1, 8'h08, 32'h0);
    $display("test fifo done");
  endtask

  task t_cmp;
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b1, 8'h00, 32'h03);
    wait_start;
    finish(12'h0aa);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata[7], 1'b0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdata, 32'h00000033);
    apb(1'b1, 8'h00, 32'h03);
    wait_start;
    @(posedge mclk);
    cmp <= 1'b1;
    finish(12'h0bb);
    cmp <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rdata[7], 1'b1);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdata, 32'h000000bb);
    apb(1'b1, 8'h04, 32'h0);
    $display("test compare done");
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset;
    t_single(1'b1);
    t_single(1'b0);
    t_chan_abort;
    t_hw;
    t_cont;
    t_fifo;
    t_cmp;
    complete_run;
  end
endmodule
`default_nettype wire
